// [hw/etc_capture.v]
// Four-channel edge time-stamp capture with input image read port
//
// Summary of operation
// R01: Image holds 5 or 15 entries chosen by variant, four bytes each.
// R02: Entry byte 0 is state, byte 1 sequence, bytes 2-3 time.
// R03: State bits 0-3 carry input lines 0-3, bits 4-7 read zero.
// R04: Stored state shows input levels after the triggering edge.
// R05: Sequence runs 0 to 127, first edge gets 1, then counts up.
// R06: A 32-bit microsecond counter starts at 0 after reset.
// R07: The microsecond counter wraps to 0 after its maximum.
// R08: Time field holds the low 16 bits of the counter.
// R09: Each qualifying edge captures time, state and sequence as one entry.
// R10: Entry n starts at byte offset four times n.
// R11: Objects 5430h-5432h give state, sequence, time; subindex s is entry s-1.
// R12: Slot subindex numbers fields from 01h, three per entry, index 6000h+slot.
// R13: Rise and fall filter delay is settable from 2 us to 3 ms.
// R14: The reader uses only the image read paths offered here.
// R15: Rising or falling trigger edges are enabled per line.
// R16: Slots fill upward and wrap to slot 0, overwriting the oldest.
// R17: Edges within one microsecond tick merge into one entry.
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.vh"
module etc_capture #(
    parameter FIFO_DEPTH = 8,
    parameter US_CYC = `ETC_US_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire input_line_0,
    input wire input_line_1,
    input wire input_line_2,
    input wire input_line_3,
    input wire variant_15,
    input wire [3:0] rise_en,
    input wire [3:0] fall_en,
    input wire [11:0] filter_us,
    input wire [7:0] slot_number,
    input wire rd_req,
    input wire [1:0] rd_mode,
    input wire [15:0] rd_addr,
    input wire [7:0] rd_sub,
    output wire rd_ready,
    output reg rd_ack,
    output reg rd_err,
    output reg [15:0] rd_data,
    output reg [31:0] us_ticker,
    output reg [7:0] last_seq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_FETCH = 3'b010;
    localparam ST_PICK = 3'b100;
    localparam DW = 8 + 8 + 16;

    ////////////////////////////////////////////////////////////////////
    // Microsecond ticker
    reg [15:0] pre_cnt;
    wire us_tick;

    assign us_tick = (pre_cnt == US_CYC[15:0] - 16'h0001);

    always @(posedge clk) begin
        if (!rst_n) begin
            pre_cnt <= 16'h0000;
            us_ticker <= 32'h0000_0000; // R06
        end else begin
            pre_cnt <= us_tick ? 16'h0000 : pre_cnt + 16'h0001;
            if (us_tick) begin
                us_ticker <= us_ticker + 32'h0000_0001; // R07
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers and filters
    wire [3:0] line_pin;
    wire [3:0] filt;
    wire [3:0] rise;
    wire [3:0] fall;
    wire [11:0] filt_lim;

    assign line_pin = {input_line_3, input_line_2, input_line_1,
                       input_line_0};
    assign filt_lim = (filter_us < `ETC_FILT_MIN_US) ? `ETC_FILT_MIN_US :
                      (filter_us > `ETC_FILT_MAX_US) ? `ETC_FILT_MAX_US :
                      filter_us; // R13

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chan
            reg s1;
            reg s2;
            reg s3;
            reg lvl;
            reg [11:0] fcnt;
            wire stable;
            wire chg;

            assign stable = (s2 == s3) && (s3 != lvl);
            assign chg = stable && (fcnt >= filt_lim); // R13
            assign filt[g] = lvl;
            assign rise[g] = chg && s3;
            assign fall[g] = chg && !s3;

            always @(posedge clk) begin
                if (!rst_n) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    lvl <= 1'b0;
                    fcnt <= 12'h000;
                end else begin
                    s1 <= line_pin[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (!stable || chg) begin
                        fcnt <= 12'h000;
                    end else if (us_tick) begin
                        fcnt <= fcnt + 12'h001;
                    end
                    if (chg) begin
                        lvl <= s3;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Edge qualification and tick merging
    wire [3:0] next_filt;
    wire hit;
    reg pend;
    reg [3:0] p_state;
    reg [15:0] p_time;
    reg [7:0] seq;
    wire [7:0] next_seq;
    wire push;
    wire f_in_ready;
    wire [DW-1:0] f_in_data;

    assign next_filt = filt ^ (rise | fall);
    assign hit = |((rise & rise_en) | (fall & fall_en)); // R15
    assign next_seq = (seq + 8'h01) & `ETC_SEQ_MASK; // R05
    assign push = pend && us_tick && f_in_ready; // R17
    assign f_in_data = {p_time, next_seq, 4'h0, p_state}; // R02 R03 R08

    always @(posedge clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
            p_state <= 4'h0;
            p_time <= 16'h0000;
            seq <= `ETC_SEQ_RESET;
            last_seq <= `ETC_SEQ_RESET;
        end else begin
            if (hit) begin
                p_state <= next_filt; // R04
            end
            if (hit && (!pend || push)) begin
                pend <= 1'b1;
                p_time <= us_ticker[15:0]; // R09
            end else if (push) begin
                pend <= 1'b0;
            end
            if (push) begin
                seq <= next_seq; // R05
                last_seq <= next_seq;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Entry FIFO
    wire f_out_valid;
    wire f_out_ready;
    wire [DW-1:0] f_out_data;

    etc_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Entry slots
    reg [2:0] state;
    reg [3:0] wr_slot;
    reg [15:0] slot_ok;
    wire [3:0] n_ent;
    wire mem_we;
    wire mem_re;
    reg [3:0] r_ent;
    wire [DW-1:0] mem_rdata;

    assign n_ent = variant_15 ? `ETC_ENTRIES_LARGE
                              : `ETC_ENTRIES_SMALL; // R01
    assign mem_re = (state == ST_FETCH);
    assign f_out_ready = !mem_re;
    assign mem_we = f_out_valid && f_out_ready;

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_slot <= 4'h0;
            slot_ok <= 16'h0000;
        end else if (mem_we) begin
            slot_ok[wr_slot] <= 1'b1;
            if (wr_slot >= n_ent - 4'h1) begin
                wr_slot <= 4'h0; // R16
            end else begin
                wr_slot <= wr_slot + 4'h1; // R16
            end
        end
    end

    etc_mem #(
        .WIDTH(DW),
        .DEPTH(16),
        .AW(4)
    ) u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(wr_slot),
        .wdata(f_out_data),
        .re(mem_re),
        .raddr(r_ent),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Request decoding
    reg t_ok;
    reg [3:0] t_ent;
    reg [2:0] t_sel;
    reg [7:0] sub_m1;
    reg [7:0] base;
    reg [7:0] fld;
    integer i;

    always @* begin
        t_ok = 1'b0;
        t_ent = 4'h0;
        t_sel = 3'h0;
        sub_m1 = rd_sub - 8'h01;
        base = 8'h00;
        fld = 8'h00;
        case (rd_mode)
            `ETC_MODE_BYTE: begin
                t_ent = rd_addr[5:2]; // R10
                t_sel = {1'b1, rd_addr[1:0]};
                t_ok = (rd_addr[15:6] == 10'h000) && (t_ent < n_ent);
            end
            `ETC_MODE_OBJECT: begin
                t_ent = sub_m1[3:0]; // R11
                t_sel = {1'b0, rd_addr[1:0] - 2'h0};
                t_ok = (rd_sub != 8'h00) && (sub_m1 < {4'h0, n_ent}) &&
                       ((rd_addr == `ETC_IDX_STATE) ||
                        (rd_addr == `ETC_IDX_SEQ) ||
                        (rd_addr == `ETC_IDX_TIME)); // R11
            end
            `ETC_MODE_SLOT: begin
                for (i = 0; i < 15; i = i + 1) begin
                    if (sub_m1 >= base) begin
                        t_ent = i[3:0]; // R12
                        fld = sub_m1 - base;
                    end
                    base = base + 8'h03;
                end
                t_sel = {1'b0, fld[1:0]};
                t_ok = (rd_sub != 8'h00) &&
                       (sub_m1 < {4'h0, n_ent} * 8'h03) &&
                       (rd_addr == `ETC_SLOT_BASE + {8'h00, slot_number});
            end
            default: begin
                t_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Read sequencer
    reg [2:0] r_sel;
    reg r_ok;
    reg [15:0] pick;
    wire [DW-1:0] ent_word;

    assign rd_ready = (state == ST_IDLE); // R14
    assign ent_word = slot_ok[r_ent] ? mem_rdata : {DW{1'b0}};

    always @* begin
        case (r_sel)
            3'h0: pick = {8'h00, ent_word[`ETC_STATE_LSB +: 8]};
            3'h1: pick = {8'h00, ent_word[`ETC_SEQ_LSB +: 8]};
            3'h2: pick = ent_word[`ETC_TIME_LSB +: 16];
            3'h4: pick = {8'h00, ent_word[7:0]};
            3'h5: pick = {8'h00, ent_word[15:8]};
            3'h6: pick = {8'h00, ent_word[23:16]};
            3'h7: pick = {8'h00, ent_word[31:24]};
            default: pick = 16'h0000;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            r_ent <= 4'h0;
            r_sel <= 3'h0;
            r_ok <= 1'b0;
            rd_ack <= 1'b0;
            rd_err <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_ack <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (rd_req) begin
                        r_ent <= t_ent;
                        r_sel <= t_sel;
                        r_ok <= t_ok;
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    state <= ST_PICK;
                end
                ST_PICK: begin
                    rd_ack <= 1'b1;
                    rd_err <= !r_ok;
                    rd_data <= r_ok ? pick : 16'h0000;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // etc_capture
`default_nettype wire

// [hw/etc_defines.vh]
// Constants for the edge time-stamp capture block
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH
`define ETC_OFS_STATE 2'h0
`define ETC_OFS_SEQ 2'h1
`define ETC_OFS_TIME 2'h2
`define ETC_STATE_LSB 0
`define ETC_SEQ_LSB 8
`define ETC_TIME_LSB 16
`define ETC_ENTRIES_SMALL 4'h5
`define ETC_ENTRIES_LARGE 4'hf
`define ETC_SEQ_MASK 8'h7f
`define ETC_SEQ_RESET 8'h00
`define ETC_IDX_STATE 16'h5430
`define ETC_IDX_SEQ 16'h5431
`define ETC_IDX_TIME 16'h5432
`define ETC_SLOT_BASE 16'h6000
`define ETC_MODE_BYTE 2'h0
`define ETC_MODE_OBJECT 2'h1
`define ETC_MODE_SLOT 2'h2
`define ETC_CLK_PERIOD_PS 4000
`define ETC_TICK_NS 1000
`define ETC_US_CYC ((`ETC_TICK_NS * 1000) / `ETC_CLK_PERIOD_PS)
`define ETC_FILT_MIN_US 12'h002
`define ETC_FILT_MAX_US 12'hbb8
`endif

// [hw/etc_mem.v]
// Entry memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module etc_mem #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [WIDTH-1:0] wdata,
    input wire re,
    input wire [AW-1:0] raddr,
    output reg [WIDTH-1:0] rdata
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule // etc_mem
`default_nettype wire

// [hw/etc_fifo.v]
// Entry FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module etc_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    localparam AW = $clog2(DEPTH);
    reg [WIDTH-1:0] buf_q [0:DEPTH-1];
    reg [AW-1:0] rd_ptr;
    reg [AW-1:0] wr_ptr;
    reg [AW:0] fill;
    wire push;
    wire pop;

    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data = buf_q[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            buf_q[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            rd_ptr <= {AW{1'b0}};
            wr_ptr <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                          : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                          : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule // etc_fifo
`default_nettype wire

// [bench/etc_capture_sva.sv]
// Port assertions for the edge time-stamp capture block
`timescale 1ns/1ps
`default_nettype none
module etc_capture_sva #(
    parameter US_CYC = 250
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_req,
    input wire logic rd_ready,
    input wire logic rd_ack,
    input wire logic rd_err,
    input wire logic [15:0] rd_data,
    input wire logic [31:0] us_ticker,
    input wire logic [7:0] last_seq
);
    logic [31:0] prev_t;
    logic [15:0] gap;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Cycles since the ticker last moved
    always @(posedge clk) begin
        prev_t <= us_ticker;
        if (!rst_n || prev_t != us_ticker)
            gap <= 16'h0000;
        else
            gap <= gap + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_ACK_LAT: assert property (rd_req && rd_ready |-> ##3 rd_ack)
        else $error("read answer not on time");
    AST_ACK_ONE: assert property (rd_ack |=> !rd_ack)
        else $error("answer pulse too long");
    AST_BUSY: assert property (rd_req && rd_ready |=> !rd_ready ##1
        !rd_ready ##1 rd_ready)
        else $error("read port busy window wrong");
    AST_ERR_ZERO: assert property (rd_ack && rd_err |->
        rd_data == 16'h0000)
        else $error("refused read returned data");
    AST_HOLD: assert property (!rd_ack |-> $stable(rd_data)
        && $stable(rd_err))
        else $error("read data moved without answer");
    AST_TICK0: assert property ($rose(rst_n) |-> us_ticker == 32'h0)
        else $error("ticker not zero after reset");
    AST_TICK_STEP: assert property (us_ticker != $past(us_ticker) |->
        us_ticker == $past(us_ticker) + 32'h1)
        else $error("ticker step wrong");
    AST_TICK_GAP: assert property (gap <= US_CYC)
        else $error("ticker stalled");
    AST_SEQ_MAX: assert property (last_seq <= 8'h7f)
        else $error("sequence out of range");
    AST_SEQ_STEP: assert property (last_seq != $past(last_seq) |->
        last_seq == (($past(last_seq) + 8'h01) & 8'h7f))
        else $error("sequence step wrong");
    COV_ERR: cover property (rd_ack && rd_err);
    COV_OK: cover property (rd_ack && !rd_err);
    COV_WRAP: cover property (last_seq == 8'h00 && $past(last_seq) == 8'h7f);
endmodule // etc_capture_sva
bind etc_capture etc_capture_sva #(.US_CYC(US_CYC)) u_etc_capture_sva (
    .clk(clk),
    .rst_n(rst_n),
    .rd_req(rd_req),
    .rd_ready(rd_ready),
    .rd_ack(rd_ack),
    .rd_err(rd_err),
    .rd_data(rd_data),
    .us_ticker(us_ticker),
    .last_seq(last_seq)
);
`default_nettype wire

// [bench/etc_reader.sv]
// Reader model for the far side of the image read port
`timescale 1ns/1ps
`default_nettype none
module etc_reader (
    input wire logic clk,
    input wire logic rd_ready,
    input wire logic rd_ack,
    input wire logic rd_err,
    input wire logic [15:0] rd_data,
    output var logic rd_req,
    output var logic [1:0] rd_mode,
    output var logic [15:0] rd_addr,
    output var logic [7:0] rd_sub
);
    initial begin
        rd_req = 1'h0;
        rd_mode = 2'h0;
        rd_addr = 16'h0000;
        rd_sub = 8'h00;
    end
    // Image reached only through the read port
    task automatic read(input logic [1:0] m, input logic [15:0] a,
        input logic [7:0] s, input int slow, output logic [15:0] d,
        output logic e);
        int n;
        n = 0;
        repeat (slow) @(posedge clk);
        #1;
        rd_req = 1'h1;
        rd_mode = m;
        rd_addr = a;
        rd_sub = s;
        while (rd_ready !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        rd_req = 1'h0;
        rd_mode = ~m;
        rd_addr = ~a;
        rd_sub = ~s;
        while (rd_ack !== 1'h1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        d = rd_data;
        e = rd_err;
        if (rd_ack !== 1'h1) begin
            d = 16'hxxxx;
            e = 1'hx;
        end
    endtask
endmodule // etc_reader
`default_nettype wire

// [bench/tb.sv]
// Testbench for the edge time-stamp capture block
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic v;
        logic [1:0] m;
        logic [15:0] a;
        logic [7:0] s;
        logic [15:0] d;
        logic e;
    } etc_row_t;
    etc_row_t rows [21] = '{
        '{1'h0, 2'h0, 16'h0000, 8'h00, 16'h0009, 1'h0},
        '{1'h0, 2'h0, 16'h0001, 8'h00, 16'h0006, 1'h0},
        '{1'h0, 2'h0, 16'h0004, 8'h00, 16'h0006, 1'h0},
        '{1'h0, 2'h0, 16'h0005, 8'h00, 16'h0002, 1'h0},
        '{1'h0, 2'h0, 16'h0010, 8'h00, 16'h0008, 1'h0},
        '{1'h0, 2'h1, 16'h5430, 8'h03, 16'h0004, 1'h0},
        '{1'h0, 2'h1, 16'h5431, 8'h05, 16'h0005, 1'h0},
        '{1'h0, 2'h2, 16'h6007, 8'h08, 16'h0003, 1'h0},
        '{1'h0, 2'h2, 16'h6007, 8'h0d, 16'h0008, 1'h0},
        '{1'h0, 2'h2, 16'h6007, 8'h01, 16'h0009, 1'h0},
        '{1'h0, 2'h0, 16'h0014, 8'h00, 16'h0000, 1'h1},
        '{1'h0, 2'h1, 16'h5430, 8'h06, 16'h0000, 1'h1},
        '{1'h0, 2'h1, 16'h5430, 8'h00, 16'h0000, 1'h1},
        '{1'h0, 2'h1, 16'h5433, 8'h01, 16'h0000, 1'h1},
        '{1'h0, 2'h2, 16'h6006, 8'h01, 16'h0000, 1'h1},
        '{1'h0, 2'h2, 16'h6007, 8'h10, 16'h0000, 1'h1},
        '{1'h0, 2'h3, 16'h0000, 8'h00, 16'h0000, 1'h1},
        '{1'h1, 2'h0, 16'h0014, 8'h00, 16'h0000, 1'h0},
        '{1'h1, 2'h1, 16'h5431, 8'h0f, 16'h0000, 1'h0},
        '{1'h1, 2'h0, 16'h003c, 8'h00, 16'h0000, 1'h1},
        '{1'h1, 2'h1, 16'h5431, 8'h10, 16'h0000, 1'h1}
    };
    logic clk;
    logic rst_n;
    logic [3:0] lines;
    logic v15;
    logic [3:0] rise_en;
    logic [3:0] fall_en;
    logic [11:0] filter_us;
    logic [7:0] slot_number;
    logic rd_req;
    logic [1:0] rd_mode;
    logic [15:0] rd_addr;
    logic [7:0] rd_sub;
    logic rd_ready;
    logic rd_ack;
    logic rd_err;
    logic [15:0] rd_data;
    logic [31:0] us_ticker;
    logic [7:0] last_seq;
    logic [31:0] cyc;
    logic [15:0] lo;
    logic [15:0] lo2;
    logic [15:0] d;
    logic e;
    int n_errors = 0;
    int tests_run = 0;
    ////////////////////////////////////////////////////////////////////////
    etc_capture #(.US_CYC(4)) u_etc_capture (
        .clk(clk), .rst_n(rst_n),
        .input_line_0(lines[0]), .input_line_1(lines[1]),
        .input_line_2(lines[2]), .input_line_3(lines[3]),
        .variant_15(v15), .rise_en(rise_en), .fall_en(fall_en),
        .filter_us(filter_us), .slot_number(slot_number),
        .rd_req(rd_req), .rd_mode(rd_mode), .rd_addr(rd_addr),
        .rd_sub(rd_sub), .rd_ready(rd_ready), .rd_ack(rd_ack),
        .rd_err(rd_err), .rd_data(rd_data), .us_ticker(us_ticker),
        .last_seq(last_seq)
    );
    etc_reader u_etc_reader (
        .clk(clk), .rd_ready(rd_ready), .rd_ack(rd_ack), .rd_err(rd_err),
        .rd_data(rd_data), .rd_req(rd_req), .rd_mode(rd_mode),
        .rd_addr(rd_addr), .rd_sub(rd_sub)
    );
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= rst_n ? cyc + 32'h1 : 32'h0;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ev(input logic [3:0] l);
        lines = l;
        lo = cyc[17:2];
        repeat (40) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'h0;
        lines = 4'h0;
        v15 = 1'h0;
        rise_en = 4'hf;
        fall_en = 4'h0;
        filter_us = 12'h000;
        slot_number = 8'h07;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'h1;
        chk(us_ticker[15:0], 16'h0000);
        chk({8'h00, last_seq}, 16'h0000);
        chk(rd_data, 16'h0000);
        ev(4'h5);
        ev(4'h4);
        ev(4'h6);
        lo2 = lo;
        fall_en = 4'hf;
        ev(4'h4);
        ev(4'h0);
        ev(4'h8);
        ev(4'h9);
        lines = 4'h1;
        repeat (3) @(posedge clk);
        #1;
        ev(4'h9);
        chk({8'h00, last_seq}, 16'h0006);
        foreach (rows[i]) begin
            v15 = rows[i].v;
            u_etc_reader.read(rows[i].m, rows[i].a, rows[i].s, i % 3, d, e);
            chk(d, rows[i].d);
            chk({15'h0000, e}, {15'h0000, rows[i].e});
        end
        v15 = 1'h0;
        u_etc_reader.read(2'h1, 16'h5432, 8'h02, 0, d, e);
        chk({15'h0000, d >= lo2 && d <= lo2 + 16'h0008}, 16'h0001);
        u_etc_reader.read(2'h0, 16'h0006, 8'h00, 0, d, e);
        lo = d;
        u_etc_reader.read(2'h0, 16'h0007, 8'h00, 0, d, e);
        lo = {d[7:0], lo[7:0]};
        chk({15'h0000, lo >= lo2 && lo <= lo2 + 16'h0008}, 16'h0001);
        for (int i = 0; i < 122; i++)
            ev(lines ^ 4'h8);
        chk({8'h00, last_seq}, 16'h0000);
        u_etc_reader.read(2'h0, 16'h0009, 8'h00, 0, d, e);
        chk(d, 16'h0000);
        u_etc_reader.read(2'h0, 16'h0005, 8'h00, 1, d, e);
        chk(d, 16'h007f);
        // Mid-run reset, held long enough for the step checks
        rst_n = 1'h0;
        lines = 4'h0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'h1;
        chk(us_ticker[15:0], 16'h0000);
        chk({8'h00, last_seq}, 16'h0000);
        u_etc_reader.read(2'h0, 16'h0000, 8'h00, 0, d, e);
        chk(d, 16'h0000);
        chk({15'h0000, e}, 16'h0000);
        results();
    end
endmodule // tb
`default_nettype wire
